/* ppr_agree_pkg.sv */
package ppr_agree_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_RX_REQ   = 8'h00;
  localparam logic [7:0] OFF_PARTNER  = 8'h04;
  localparam logic [7:0] OFF_CAP      = 8'h08;
  localparam logic [7:0] OFF_CMD      = 8'h0c;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_RESP     = 8'h14;
  localparam logic [7:0] OFF_TBL_SEL  = 8'h18;
  localparam logic [7:0] OFF_TBL_DATA = 8'h1c;

  // command register bit positions
  localparam int CMD_EVAL       = 0;
  localparam int CMD_COMMIT     = 1;
  localparam int CMD_ABORT      = 2;
  localparam int CMD_INDET      = 3;
  localparam int CMD_CLEAR_ALL  = 4;
  localparam int CMD_PARITY_OK  = 5;
  localparam int CMD_ATN_SEEN   = 6;

  // status register bit positions
  localparam int STS_RESP_VALID = 0;
  localparam int STS_BUS_FREE   = 1;
  localparam int STS_WDTR_REQ   = 2;
  localparam int STS_COMMIT_OK  = 3;
  localparam int STS_ANSWER_PPR = 4;
  localparam int STS_WDTR_EXP   = 8;

  // option field positions inside opts = {qas, dt, iu}
  localparam int OPT_IU  = 0;
  localparam int OPT_DT  = 1;
  localparam int OPT_QAS = 2;

  localparam int N_PARTNERS = 16;
  localparam int ID_W       = 4;
  localparam int N_COMBOS   = 4;

  // legal option combinations, widest first at the top index
  localparam logic [N_COMBOS-1:0][2:0] LEGAL_COMBOS = {3'h7, 3'h3, 3'h2, 3'h0};

  localparam logic [7:0] WIDTH_NARROW   = 8'h00;
  localparam logic [7:0] WIDTH_WIDE     = 8'h01;
  localparam logic [7:0] WDTR_EXP_ASYNC = 8'h00;
  localparam logic [7:0] PERIOD_MIN_LEGAL = 8'h08;
  localparam logic [7:0] OFFSET_ASYNC   = 8'h00;

  // one parallel protocol request payload, also one stored agreement
  typedef struct packed {
    logic [2:0] opts;
    logic [7:0] width;
    logic [7:0] offset;
    logic [7:0] period;
  } ppr_msg_t;

  localparam ppr_msg_t AGREE_DEFAULT = '{opts: 3'h0, width: 8'h00, offset: 8'h00,
                                         period: 8'h00};

  // target receive capability
  typedef struct packed {
    logic [3:0] combo_mask;
    logic       wide_ok;
    logic [7:0] max_offset;
    logic [7:0] min_period;
  } ppr_cap_t;

  localparam ppr_cap_t CAP_RESET = '{combo_mask: 4'hf, wide_ok: 1'b1,
                                     max_offset: 8'h3f, min_period: 8'h0a};

  // agreement as seen by the data-phase engine
  typedef struct packed {
    logic       wide;
    logic [7:0] offset;
    logic [7:0] period;
    logic       iu_en;
    logic       dt_en;
    logic       qas_en;
  } xfer_mode_t;

endpackage

/* ppr_opt_legalize.sv */
`timescale 1ns/1ps
`default_nettype none
module ppr_opt_legalize (
  // requested options and limits
  input  wire logic [2:0] req_opts_i,
  input  wire logic [3:0] combo_mask_i,
  input  wire logic       wide_i,
  // chosen legal options
  output logic      [2:0] opts_o
);
  import ppr_agree_pkg::*;

  // widest legal combo that is a subset of the request and is supported
  always_comb begin
    opts_o = LEGAL_COMBOS[0];
    for (int k = 0; k < N_COMBOS; k++) begin
      if (((LEGAL_COMBOS[k] & req_opts_i) == LEGAL_COMBOS[k]) &&
          (combo_mask_i[k] || (k == 0)) &&
          (wide_i || (LEGAL_COMBOS[k][OPT_DT:OPT_IU] == 2'h0))) begin
        opts_o = LEGAL_COMBOS[k];
      end
    end
  end

endmodule
`default_nettype wire

/* ppr_resp_fit.sv */
`timescale 1ns/1ps
`default_nettype none
module ppr_resp_fit (
  // request and capability
  input  wire ppr_agree_pkg::ppr_msg_t rx_i,
  input  wire ppr_agree_pkg::ppr_cap_t cap_i,
  // fitted limits
  output logic [7:0]                   period_o,
  output logic [7:0]                   offset_o,
  output logic [7:0]                   width_o,
  output logic [2:0]                   req_opts_o
);
  import ppr_agree_pkg::*;

  logic [7:0] floor_period;

  always_comb begin
    floor_period = (cap_i.min_period < PERIOD_MIN_LEGAL) ? PERIOD_MIN_LEGAL : cap_i.min_period;
    // larger period, smaller offset, narrower width only where needed
    period_o = (rx_i.period < floor_period) ? floor_period : rx_i.period;
    offset_o = (rx_i.offset > cap_i.max_offset) ? cap_i.max_offset : rx_i.offset;
    width_o  = ((rx_i.width == WIDTH_WIDE) && cap_i.wide_ok) ? WIDTH_WIDE
                                                              : WIDTH_NARROW;
    // async offer ignores every option except qas
    req_opts_o = (offset_o == OFFSET_ASYNC) ? (rx_i.opts & 3'h4) : rx_i.opts;
  end

endmodule
`default_nettype wire

/* ppr_agree.sv */
`timescale 1ns/1ps
`default_nettype none
module ppr_agree (
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      resetn_i,
  // apb slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [7:0]                paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // data-phase engine side
  input  wire logic [ppr_agree_pkg::ID_W-1:0] cur_partner_i,
  input  wire logic                      data_phase_i,
  output ppr_agree_pkg::xfer_mode_t      xfer_mode_o,
  // sequencer side
  output logic                           bus_free_req_o,
  output logic                           wdtr_req_o
);
  import ppr_agree_pkg::*;

  ppr_msg_t            rx_ff;
  ppr_msg_t            resp_ff;
  ppr_msg_t            nxt_resp;
  ppr_cap_t            cap_ff;
  logic [ID_W-1:0]     neg_id_ff;
  logic [ID_W-1:0]     tbl_sel_ff;
  ppr_msg_t            table_ff [N_PARTNERS];
  logic                resp_valid_ff;
  logic                bus_free_ff;
  logic                wdtr_ff;
  logic                commit_ok_ff;
  logic                bus_free_pulse_ff;
  logic [31:0]         prdata_ff;
  logic                wide_ff;
  logic [7:0]          offset_ff;
  logic [7:0]          period_ff;
  logic [2:0]          opts_ff;

  logic                setup;
  logic                wr;
  logic                mapped;
  logic [31:0]         rd_word;
  logic [7:0]          fit_period;
  logic [7:0]          fit_offset;
  logic [7:0]          fit_width;
  logic [2:0]          fit_req_opts;
  logic [2:0]          fit_opts;
  logic                cmd_wr;
  logic                do_eval;
  logic                do_commit;
  logic                commit_good;
  logic                do_fallback;
  logic                do_indet;
  logic                do_clear_all;
  logic                iu_changed;
  logic                sts_wr;
  ppr_msg_t            cur_entry;

  // apb decode, zero wait states
  assign setup    = psel_i & ~penable_i;
  assign wr       = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  assign prdata_o = prdata_ff;

  always_comb begin
    mapped = 1'b1;
    case (paddr_i)
      OFF_RX_REQ, OFF_PARTNER, OFF_CAP, OFF_CMD,
      OFF_STATUS, OFF_RESP, OFF_TBL_SEL, OFF_TBL_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr_o = psel_i & penable_i & ~mapped;

  // response fitting and option legalisation
  ppr_resp_fit u_fit (
    .rx_i       (rx_ff),
    .cap_i      (cap_ff),
    .period_o   (fit_period),
    .offset_o   (fit_offset),
    .width_o    (fit_width),
    .req_opts_o (fit_req_opts)
  );

  ppr_opt_legalize u_legal (
    .req_opts_i   (fit_req_opts),
    .combo_mask_i (cap_ff.combo_mask),
    .wide_i       (fit_width == WIDTH_WIDE),
    .opts_o       (fit_opts)
  );

  always_comb begin
    nxt_resp.period = fit_period;
    nxt_resp.offset = fit_offset;
    nxt_resp.width  = fit_width;
    nxt_resp.opts   = fit_opts;
  end

  // command decode, clear-all wins over every other command
  assign cmd_wr       = wr & (paddr_i == OFF_CMD);
  assign do_clear_all = cmd_wr & pwdata_i[CMD_CLEAR_ALL];
  assign do_indet     = cmd_wr & pwdata_i[CMD_INDET] & ~do_clear_all;
  assign do_commit    = cmd_wr & pwdata_i[CMD_COMMIT] & resp_valid_ff & ~do_clear_all &
                        ~do_indet & ~pwdata_i[CMD_ABORT];
  assign commit_good  = do_commit & pwdata_i[CMD_PARITY_OK] & ~pwdata_i[CMD_ATN_SEEN];
  assign do_fallback  = (cmd_wr & pwdata_i[CMD_ABORT] & ~do_clear_all & ~do_indet) |
                        (do_commit & ~commit_good);
  assign do_eval      = cmd_wr & pwdata_i[CMD_EVAL] & ~do_clear_all & ~do_indet &
                        ~pwdata_i[CMD_ABORT] & ~pwdata_i[CMD_COMMIT];
  assign iu_changed   = table_ff[neg_id_ff].opts[OPT_IU] != resp_ff.opts[OPT_IU];
  assign sts_wr       = wr & (paddr_i == OFF_STATUS);

  // software-written registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_ff      <= AGREE_DEFAULT;
      neg_id_ff  <= '0;
      cap_ff     <= CAP_RESET;
      tbl_sel_ff <= '0;
    end else if (wr) begin
      case (paddr_i)
        OFF_RX_REQ:  rx_ff      <= pwdata_i[$bits(ppr_msg_t)-1:0];
        OFF_PARTNER: neg_id_ff  <= pwdata_i[ID_W-1:0];
        OFF_CAP:     cap_ff     <= pwdata_i[$bits(ppr_cap_t)-1:0];
        OFF_TBL_SEL: tbl_sel_ff <= pwdata_i[ID_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // response built on evaluate, always a ppr answer
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resp_ff       <= AGREE_DEFAULT;
      resp_valid_ff <= 1'b0;
    end else if (do_eval) begin
      resp_ff       <= nxt_resp;
      resp_valid_ff <= 1'b1;
    end else if (do_commit | do_fallback | do_indet | do_clear_all) begin
      resp_valid_ff <= 1'b0;
    end
  end

  // agreement table, one entry per partner id
  for (genvar g = 0; g < N_PARTNERS; g++) begin : g_entry
    logic hit;
    assign hit = (neg_id_ff == ID_W'(g));
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        table_ff[g] <= AGREE_DEFAULT;
      end else if (do_clear_all) begin
        table_ff[g] <= AGREE_DEFAULT;
      end else if (hit & (do_indet | do_fallback)) begin
        table_ff[g] <= AGREE_DEFAULT;
      end else if (hit & commit_good) begin
        table_ff[g] <= resp_ff;
      end
    end
  end

  // bus free request on iu change, one-cycle pulse plus sticky status
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_free_pulse_ff <= 1'b0;
    end else begin
      bus_free_pulse_ff <= commit_good & iu_changed;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_free_ff <= 1'b0;
    end else if (commit_good & iu_changed) begin
      bus_free_ff <= 1'b1;
    end else if (sts_wr & pwdata_i[STS_BUS_FREE]) begin
      bus_free_ff <= 1'b0;
    end
  end

  // narrow async request after an indeterminate agreement
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdtr_ff <= 1'b0;
    end else if (do_indet) begin
      wdtr_ff <= 1'b1;
    end else if (sts_wr & pwdata_i[STS_WDTR_REQ]) begin
      wdtr_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      commit_ok_ff <= 1'b0;
    end else if (do_commit) begin
      commit_ok_ff <= commit_good;
    end else if (do_fallback | do_indet | do_clear_all) begin
      commit_ok_ff <= 1'b0;
    end
  end

  assign bus_free_req_o = bus_free_pulse_ff;
  assign wdtr_req_o     = wdtr_ff;

  // read mux, sampled in the setup cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr_i)
      OFF_RX_REQ:   rd_word[$bits(ppr_msg_t)-1:0] = rx_ff;
      OFF_PARTNER:  rd_word[ID_W-1:0] = neg_id_ff;
      OFF_CAP:      rd_word[$bits(ppr_cap_t)-1:0] = cap_ff;
      OFF_STATUS: begin
        rd_word[STS_RESP_VALID] = resp_valid_ff;
        rd_word[STS_BUS_FREE]   = bus_free_ff;
        rd_word[STS_WDTR_REQ]   = wdtr_ff;
        rd_word[STS_COMMIT_OK]  = commit_ok_ff;
        rd_word[STS_ANSWER_PPR] = 1'b1;
        rd_word[STS_WDTR_EXP +: 8] = WDTR_EXP_ASYNC;
      end
      OFF_RESP:     rd_word[$bits(ppr_msg_t)-1:0] = resp_ff;
      OFF_TBL_SEL:  rd_word[ID_W-1:0] = tbl_sel_ff;
      OFF_TBL_DATA: rd_word[$bits(ppr_msg_t)-1:0] = table_ff[tbl_sel_ff];
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup & ~pwrite_i) begin
      prdata_ff <= rd_word;
    end
  end

  // agreement presented to the data engine for the active partner
  assign cur_entry = table_ff[cur_partner_i];

  // non-data phases run narrow and async
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_ff   <= 1'b0;
      offset_ff <= OFFSET_ASYNC;
    end else begin
      wide_ff   <= data_phase_i & (cur_entry.width == WIDTH_WIDE);
      offset_ff <= data_phase_i ? cur_entry.offset : OFFSET_ASYNC;
    end
  end

  // period limit follows the entry in every phase
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      period_ff <= AGREE_DEFAULT.period;
    end else begin
      period_ff <= cur_entry.period;
    end
  end

  // options of the entry, always a legal combination
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opts_ff <= AGREE_DEFAULT.opts;
    end else begin
      opts_ff <= cur_entry.opts;
    end
  end

  assign xfer_mode_o = '{wide: wide_ff, offset: offset_ff, period: period_ff,
                         iu_en: opts_ff[OPT_IU], dt_en: opts_ff[OPT_DT],
                         qas_en: opts_ff[OPT_QAS]};

endmodule
`default_nettype wire

/* ppr_agree_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ppr_agree_checker (
  // watched ports
  input wire logic                             ref_clk_i,
  input wire logic                             resetn_i,
  input wire logic                             psel_i,
  input wire logic                             penable_i,
  input wire logic                             pwrite_i,
  input wire logic [7:0]                       paddr_i,
  input wire logic [31:0]                      pwdata_i,
  input wire logic [31:0]                      prdata_o,
  input wire logic                             pready_o,
  input wire logic                             pslverr_o,
  input wire logic [ppr_agree_pkg::ID_W-1:0]   cur_partner_i,
  input wire logic                             data_phase_i,
  input wire ppr_agree_pkg::xfer_mode_t        xfer_mode_o,
  input wire logic                             bus_free_req_o,
  input wire logic                             wdtr_req_o
);
  import ppr_agree_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic cmd_wr;
  assign cmd_wr = psel_i && penable_i && pwrite_i && paddr_i == OFF_CMD;

  idle_narrow_a: assert property (
    !data_phase_i |=> !xfer_mode_o.wide && xfer_mode_o.offset == 8'h00)
    else $error("wide or sync mode outside data phase");
  legal_opts_a: assert property (
    !(xfer_mode_o.qas_en && !xfer_mode_o.iu_en) && !(xfer_mode_o.iu_en && !xfer_mode_o.dt_en))
    else $error("reserved option combination in use");
  wide_opts_a: assert property (
    data_phase_i |=> (xfer_mode_o.dt_en || xfer_mode_o.iu_en) |-> xfer_mode_o.wide)
    else $error("dt or iu without wide path");
  async_opts_a: assert property (
    data_phase_i ##1 xfer_mode_o.offset == 8'h00 |-> !xfer_mode_o.dt_en && !xfer_mode_o.iu_en)
    else $error("async agreement with options");
  free_pulse_a: assert property (bus_free_req_o |=> !bus_free_req_o)
    else $error("bus free request longer than one cycle");
  free_cause_a: assert property (
    bus_free_req_o |-> $past(cmd_wr && pwdata_i[CMD_COMMIT] && pwdata_i[CMD_PARITY_OK]
                             && !pwdata_i[CMD_ATN_SEEN]))
    else $error("bus free request without clean commit");
  wdtr_cause_a: assert property ($rose(wdtr_req_o) |-> $past(cmd_wr && pwdata_i[CMD_INDET]))
    else $error("width request without indeterminate command");
  wdtr_set_a: assert property (
    cmd_wr && pwdata_i[CMD_INDET] && !pwdata_i[CMD_CLEAR_ALL] |=> wdtr_req_o)
    else $error("indeterminate command did not request width");
  ppr_answer_a: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i == OFF_STATUS |-> prdata_o[STS_ANSWER_PPR])
    else $error("answer kind is not a protocol response");

  cover property (bus_free_req_o);
  cover property ($rose(wdtr_req_o));
  cover property (xfer_mode_o.qas_en && xfer_mode_o.wide);
endmodule

bind ppr_agree ppr_agree_checker chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .cur_partner_i(cur_partner_i), .data_phase_i(data_phase_i), .xfer_mode_o(xfer_mode_o),
  .bus_free_req_o(bus_free_req_o), .wdtr_req_o(wdtr_req_o));
`default_nettype wire

/* initiator_model.sv */
`timescale 1ns/1ps
`default_nettype none
module initiator_model (
  // request and exchange outcome
  output var ppr_agree_pkg::ppr_msg_t req_o,
  output var logic                    clean_o
);
  import ppr_agree_pkg::*;
  // fresh request per exchange; options swept by caller
  task automatic next(input logic [2:0] opts);
    req_o.opts   = opts;
    req_o.width  = 8'($urandom_range(2));
    req_o.offset = ($urandom_range(3) == 0) ? OFFSET_ASYNC : 8'($urandom);
    req_o.period = 8'($urandom);
    clean_o      = ($urandom_range(3) != 0);
  endtask
  initial begin
    req_o   = '0;
    clean_o = 1'b0;
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import ppr_agree_pkg::*;
  logic            ref_clk_i = 0, resetn_i = 0, psel = 0, pen = 0, pwr = 0, dphase = 0;
  logic [7:0]      paddr = 0;
  logic [31:0]     pwdata = 0, prdata;
  logic            pready, pslverr, bfree, wdtr, bf, lastok, cl;
  logic [ID_W-1:0] cur = 0, id;
  xfer_mode_t      xm;
  ppr_msg_t        tbl[N_PARTNERS], rsp;
  ppr_cap_t        cap;
  logic [32:0]     exp_q[$];
  int              fails = 0, comparisons = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;
  ppr_agree DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cur_partner_i(cur), .data_phase_i(dphase), .xfer_mode_o(xm),
    .bus_free_req_o(bfree), .wdtr_req_o(wdtr));
  initiator_model ini (.req_o(), .clean_o());

  task automatic end_sim;
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1) @(posedge ref_clk_i);
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // read results: {pslverr, prdata} against oldest note
  always @(posedge ref_clk_i) if (psel && pen && !pwr && pready)
    `CHK({pslverr, prdata}, exp_q.pop_front())

  function automatic ppr_msg_t fit(ppr_msg_t r, ppr_cap_t c);
    ppr_msg_t o;
    o.period = r.period < c.min_period ? c.min_period : r.period;
    if (o.period < PERIOD_MIN_LEGAL) o.period = PERIOD_MIN_LEGAL;
    o.offset = r.offset > c.max_offset ? c.max_offset : r.offset;
    o.width = (r.width == WIDTH_WIDE && c.wide_ok) ? WIDTH_WIDE : WIDTH_NARROW;
    o.opts = 3'h0;
    for (int i = 1; i < N_COMBOS; i++)
      if ((LEGAL_COMBOS[i] & ~r.opts) == 3'h0 && c.combo_mask[i] && o.width == WIDTH_WIDE)
        o.opts = LEGAL_COMBOS[i];
    if (o.offset == OFFSET_ASYNC) o.opts = 3'h0;
    return o;
  endfunction
  function automatic xfer_mode_t mode_of(ppr_msg_t m);
    return '{wide: m.width == WIDTH_WIDE, offset: m.offset, period: m.period,
             iu_en: m.opts[OPT_IU], dt_en: m.opts[OPT_DT], qas_en: m.opts[OPT_QAS]};
  endfunction
  task automatic xchk(input logic [ID_W-1:0] p);
    @(posedge ref_clk_i);
    cur <= p; dphase <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK(xm, mode_of(tbl[p]))
    @(posedge ref_clk_i) dphase <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'heae3));
    for (int i = 0; i < N_PARTNERS; i++) tbl[i] = AGREE_DEFAULT;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(OFF_CAP, {12'h0, CAP_RESET});
    rd(OFF_STATUS, 33'h10);
    rd(OFF_TBL_DATA, 33'h0);
    rd(OFF_CMD, 33'h0);
    rd(8'h20, {1'b1, 32'h0});
    lastok = 1'b0;
    for (int i = 0; i < 16; i++) begin
      id = ID_W'($urandom);
      ini.next(3'(i));
      cl = ini.clean_o;
      cap = '{4'($urandom), 1'($urandom), 8'($urandom), 8'($urandom)};
      rsp = fit(ini.req_o, cap);
      bus(1'b1, OFF_CAP, {11'h0, cap});
      bus(1'b1, OFF_PARTNER, {28'h0, id});
      bus(1'b1, OFF_RX_REQ, {5'h0, ini.req_o});
      bus(1'b1, OFF_CMD, 32'h1);
      rd(OFF_RESP, {6'h0, rsp});
      rd(OFF_STATUS, {29'h1, lastok, 3'h1});
      bf = cl && (rsp.opts[OPT_IU] != tbl[id].opts[OPT_IU]);
      bus(1'b1, OFF_CMD, cl ? 32'h22 : 32'h62);
      #1 `CHK(bfree, bf)
      tbl[id] = cl ? rsp : AGREE_DEFAULT;
      lastok = cl;
      rd(OFF_STATUS, {29'h1, lastok, 1'b0, bf, 1'b0});
      bus(1'b1, OFF_STATUS, 32'h6);
      bus(1'b1, OFF_TBL_SEL, {28'h0, id});
      rd(OFF_TBL_DATA, {6'h0, tbl[id]});
      xchk(id);
      xchk(id + 4'h1);
    end
    bus(1'b1, OFF_CMD, 32'h8);
    tbl[id] = AGREE_DEFAULT;
    xchk(id);
    `CHK(wdtr, 1'b1)
    bus(1'b1, OFF_PARTNER, {28'h0, id + 4'h1});
    bus(1'b1, OFF_CMD, 32'h4);
    tbl[id + 4'h1] = AGREE_DEFAULT;
    xchk(id + 4'h1);
    bus(1'b1, OFF_STATUS, 32'h4);
    bus(1'b1, OFF_CMD, 32'h10);
    for (int i = 0; i < N_PARTNERS; i++) tbl[i] = AGREE_DEFAULT;
    for (int i = 0; i < N_PARTNERS; i++) xchk(ID_W'(i));
    `CHK(wdtr, 1'b0)
    end_sim;
  end

  initial begin
    #500000;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
